// *** logic/hdps_link.sv ***
// polled slave link controller: frame parser, reply sequencer and modem control timing
// assumes a polling master on a half-duplex line; configuration is held steady by the user
// Function
// - bit rate 300 doubling to 38.4K, parity none or even, same at both ends
// - only polls and packets addressed to our station number are accepted
// - with suppression on and nothing queued, a poll gets no reply; with nothing queued and suppression off, EOT; else the queued message
// - with duplicate detection on, a repeat of the last accepted packet is discarded
// - poll timeout counts 20 ms units only while a self-initiated message waits
// - poll timeout expiry drops the pending message and flags an error
// - poll timeout of zero disables the timeout altogether
// - RTS stays on for the off delay after the last character leaves
// - after RTS rises wait the send delay, then start only once CTS is active
// - unacknowledged message is resent up to the retry count, then flagged as error
// - without handshaking wait the pre-transmit delay before every transmission
// - with modem handshaking pre-transmit delay spaces last received character from RTS
// - control line picks no handshaking or RTS/CTS gating of every transmission
`timescale 1ns/1ps
module hdps_link #(
  parameter int MS_CYC       = hdps_pkg::MS_TICK_CYC,
  parameter int BIT_DIV_BASE = hdps_pkg::BIT_DIV_BASE
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire hdps_pkg::hdps_cfg_type cfg,
  input  wire logic                  rxd,
  input  wire logic                  cts,
  output logic                       txd,
  output logic                       rts,
  input  wire logic                  outgoing_message_request,
  input  wire logic [7:0]            outgoing_data,
  output logic                       out_ready,
  output logic                       msg_done,
  output logic                       msg_error,
  output logic                       rx_msg_valid,
  output logic [7:0]                 rx_msg_data,
  output logic [7:0]                 rx_msg_tag
);
  import hdps_pkg::*;

  typedef struct packed {
    hdps_parse_type p;
    logic [7:0]     r_stn, r_tag, r_data, r_ck0;
    hdps_tx_type    t;
    hdps_kind_type  kind;
    logic [2:0]     idx;
    logic [15:0]    dly;
    logic [15:0]    quiet;
    logic [15:0]    poll_cnt;
    logic           pend;
    logic [7:0]     m_data;
    logic [7:0]     m_tag;
    logic [7:0]     tries;
    logic           last_ok;
    logic [7:0]     last_tag;
    logic [7:0]     last_data;
    logic           tx_start;
    logic [7:0]     tx_byte;
    logic           rts;
    logic           rdy;
    logic           done;
    logic           err;
    logic           rx_v;
    logic [7:0]     rx_data;
    logic [7:0]     rx_tag;
  } hdps_link_st_type;

  hdps_link_st_type s_q, s_d;
  logic             ms_tick, slow_tick;
  logic             u_busy, u_valid, u_err;
  logic [7:0]       u_byte;
  logic [DIV_W-1:0] bit_div;
  logic             ev_poll, ev_pkt, ev_ack, ev_nak;
  logic [15:0]      ck_rx, ck_tx;
  logic [2:0]       tx_len;

  // doubling rates come from halving one divider
  assign bit_div = DIV_W'(BIT_DIV_BASE) >> cfg.baud_sel;

  hdps_tick #(.MS_CYC(MS_CYC)) u_tick (
    .core_clk  (core_clk),
    .reset     (reset),
    .ms_tick   (ms_tick),
    .slow_tick (slow_tick)
  );

  hdps_uart u_uart (
    .core_clk    (core_clk),
    .reset       (reset),
    .bit_div     (bit_div),
    .parity_even (cfg.parity_even),
    .rxd         (rxd),
    .tx_start    (s_q.tx_start),
    .tx_byte     (s_q.tx_byte),
    .tx_busy     (u_busy),
    .txd         (txd),
    .rx_valid    (u_valid),
    .rx_byte     (u_byte),
    .rx_err      (u_err)
  );

  // check value over station, tag and data; crc low byte goes first
  function automatic logic [15:0] check_of(input logic crc, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] c);
    logic [15:0] x;
    logic [23:0] v;
    x = '0;
    v = {c, b, a};
    if (crc) begin
      for (int i = 0; i < 24; i++) begin
        x = (x[0] ^ v[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
    end else begin
      x = {8'h00, 8'h00 - (a + b + c)};
    end
    return x;
  endfunction

  assign ck_rx  = check_of(cfg.use_crc, s_q.r_stn, s_q.r_tag, s_q.r_data);
  assign ck_tx  = check_of(cfg.use_crc, cfg.station_number, s_q.m_tag, s_q.m_data);
  assign tx_len = (s_q.kind == K_ACK) ? LEN_ACK :
                  (s_q.kind == K_EOT) ? LEN_EOT :
                  LEN_MSG_HDR + (cfg.use_crc ? 3'h2 : 3'h1);

  always_comb begin
    s_d          = s_q;
    s_d.tx_start = 1'b0;
    s_d.done     = 1'b0;
    s_d.err      = 1'b0;
    s_d.rx_v     = 1'b0;
    ev_poll      = 1'b0;
    ev_pkt       = 1'b0;
    ev_ack       = 1'b0;
    ev_nak       = 1'b0;
    // line quiet time since the last received character
    if (u_valid) begin
      s_d.quiet = '0;
    end else if (ms_tick && s_q.quiet != 16'hffff) begin
      s_d.quiet = s_q.quiet + 16'h0001;
    end
    // frame parser; a parity or stop fault drops the frame
    if (u_valid) begin
      if (u_err) begin
        s_d.p = P_IDLE;
      end else begin
        case (s_q.p)
          P_IDLE: begin
            if (u_byte == CH_ENQ) begin
              s_d.p = P_PSTN;
            end else if (u_byte == CH_STX) begin
              s_d.p = P_STN;
            end
            ev_ack = (u_byte == CH_ACK);
            ev_nak = (u_byte == CH_NAK);
          end
          P_PSTN: begin
            ev_poll = (u_byte == cfg.station_number);
            s_d.p   = P_IDLE;
          end
          P_STN: begin
            s_d.r_stn = u_byte;
            s_d.p     = P_TAG;
          end
          P_TAG: begin
            s_d.r_tag = u_byte;
            s_d.p     = P_DAT;
          end
          P_DAT: begin
            s_d.r_data = u_byte;
            s_d.p      = P_ETX;
          end
          P_ETX: begin
            s_d.p = (u_byte == CH_ETX) ? P_CK0 : P_IDLE;
          end
          P_CK0: begin
            s_d.r_ck0 = u_byte;
            s_d.p     = cfg.use_crc ? P_CK1 : P_IDLE;
            ev_pkt    = !cfg.use_crc && (u_byte == ck_rx[7:0]);
          end
          default: begin
            s_d.p  = P_IDLE;
            ev_pkt = ({u_byte, s_q.r_ck0} == ck_rx);
          end
        endcase
      end
    end
    ev_pkt = ev_pkt && (s_q.r_stn == cfg.station_number);
    // deliver a good packet once; a repeat is acknowledged but not passed on
    if (ev_pkt) begin
      if (!(cfg.dup_detect && s_q.last_ok && s_q.r_tag == s_q.last_tag
            && s_q.r_data == s_q.last_data)) begin
        s_d.rx_v    = 1'b1;
        s_d.rx_data = s_q.r_data;
        s_d.rx_tag  = s_q.r_tag;
      end
      s_d.last_ok   = 1'b1;
      s_d.last_tag  = s_q.r_tag;
      s_d.last_data = s_q.r_data;
    end
    // accept a new outgoing message only when none is pending
    if (outgoing_message_request && !s_q.pend) begin
      s_d.pend     = 1'b1;
      s_d.m_data   = outgoing_data;
      s_d.m_tag    = s_q.m_tag + 8'h01;
      s_d.tries    = '0;
      s_d.poll_cnt = '0;
    end
    // reply sequencer
    case (s_q.t)
      T_IDLE: begin
        s_d.dly = '0;
        s_d.idx = '0;
        if (ev_pkt) begin
          s_d.kind = K_ACK;
          s_d.t    = T_PRE;
        end else if (ev_poll) begin
          s_d.poll_cnt = '0;
          if (s_q.pend) begin
            s_d.kind = K_MSG;
            s_d.t    = T_PRE;
          end else if (!cfg.idle_reply_suppress) begin
            s_d.kind = K_EOT;
            s_d.t    = T_PRE;
          end
        end else if (s_q.pend) begin
          if (slow_tick) begin
            s_d.poll_cnt = s_q.poll_cnt + 16'h0001;
          end
          if (cfg.poll_timeout != 16'h0000 && s_q.poll_cnt >= cfg.poll_timeout) begin
            s_d.pend = 1'b0;
            s_d.err  = 1'b1;
          end
        end
      end
      T_PRE: begin
        if (cfg.modem_hs) begin
          if (s_q.quiet >= cfg.pre_tx_delay) begin
            s_d.rts = 1'b1;
            s_d.t   = T_SDLY;
          end
        end else if (s_q.dly >= cfg.pre_tx_delay) begin
          s_d.t = T_SEND;
        end else if (ms_tick) begin
          s_d.dly = s_q.dly + 16'h0001;
        end
      end
      T_SDLY: begin
        if (s_q.dly >= cfg.rts_send_delay) begin
          s_d.t = T_CTS;
        end else if (slow_tick) begin
          s_d.dly = s_q.dly + 16'h0001;
        end
      end
      T_CTS: begin
        if (cts) begin
          s_d.t = T_SEND;
        end
      end
      T_SEND: begin
        // wait for the serialiser to finish before the next byte or turnaround
        if (!u_busy && !s_q.tx_start) begin
          if (s_q.idx == tx_len) begin
            s_d.dly = '0;
            s_d.t   = cfg.modem_hs ? T_OFF : ((s_q.kind == K_MSG) ? T_WACK : T_IDLE);
          end else begin
            s_d.tx_start = 1'b1;
            s_d.idx      = s_q.idx + 3'h1;
            case (s_q.idx)
              3'h0:    s_d.tx_byte = (s_q.kind == K_ACK) ? CH_ACK :
                                     (s_q.kind == K_EOT) ? CH_EOT : CH_STX;
              3'h1:    s_d.tx_byte = cfg.station_number;
              3'h2:    s_d.tx_byte = s_q.m_tag;
              3'h3:    s_d.tx_byte = s_q.m_data;
              3'h4:    s_d.tx_byte = CH_ETX;
              3'h5:    s_d.tx_byte = ck_tx[7:0];
              default: s_d.tx_byte = ck_tx[15:8];
            endcase
          end
        end
      end
      T_OFF: begin
        if (s_q.dly >= cfg.rts_off_delay) begin
          s_d.rts = 1'b0;
          s_d.dly = '0;
          s_d.t   = (s_q.kind == K_MSG) ? T_WACK : T_IDLE;
        end else if (slow_tick) begin
          s_d.dly = s_q.dly + 16'h0001;
        end
      end
      default: begin
        // the master must answer a sent message; silence counts as a refusal
        if (slow_tick) begin
          s_d.dly = s_q.dly + 16'h0001;
        end
        if (ev_ack) begin
          s_d.pend = 1'b0;
          s_d.done = 1'b1;
          s_d.t    = T_IDLE;
        end else if (ev_nak || s_q.dly >= ACK_WAIT_20) begin
          s_d.t        = T_IDLE;
          s_d.poll_cnt = '0;
          if (s_q.tries < cfg.msg_retries) begin
            s_d.tries = s_q.tries + 8'h01;
          end else begin
            s_d.pend = 1'b0;
            s_d.err  = 1'b1;
          end
        end
      end
    endcase
    s_d.rdy = !s_d.pend;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q       <= '0;            // all idle states encode as zero
      s_q.rdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rts          = s_q.rts;
  assign out_ready    = s_q.rdy;
  assign msg_done     = s_q.done;
  assign msg_error    = s_q.err;
  assign rx_msg_valid = s_q.rx_v;
  assign rx_msg_data  = s_q.rx_data;
  assign rx_msg_tag   = s_q.rx_tag;
endmodule

// *** logic/hdps_pkg.sv ***
// shared constants and carrier types for the polled slave link controller
// assumes one 50 MHz clock and a synchronous active-high reset
package hdps_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_TICK_NS    = 1_000_000;
  localparam int MS_TICK_CYC   = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int SLOW_TICK_MS  = 20;
  localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int BAUD_MIN      = 300;
  localparam int BIT_DIV_BASE  = CLK_HZ / BAUD_MIN;
  localparam int DIV_W         = 18;

  // line control characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;

  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam logic [15:0] ACK_WAIT_20 = 16'h0032;
  localparam logic [7:0]  DEF_STATION = 8'h01;
  localparam logic [2:0]  LEN_ACK     = 3'h1;
  localparam logic [2:0]  LEN_EOT     = 3'h2;
  localparam logic [2:0]  LEN_MSG_HDR = 3'h5;

  typedef struct packed {
    logic [2:0]  baud_sel;            // 300 << baud_sel
    logic        parity_even;
    logic [7:0]  station_number;
    logic        modem_hs;
    logic        use_crc;             // else block_check_byte
    logic        idle_reply_suppress;
    logic        dup_detect;
    logic [15:0] poll_timeout;        // 20 ms units, 0 = off
    logic [15:0] rts_off_delay;       // 20 ms units
    logic [15:0] rts_send_delay;      // 20 ms units
    logic [7:0]  msg_retries;
    logic [15:0] pre_tx_delay;        // 1 ms units
  } hdps_cfg_type;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_PSTN = 3'b001, P_STN = 3'b010, P_TAG = 3'b011,
    P_DAT  = 3'b100, P_ETX  = 3'b101, P_CK0 = 3'b110, P_CK1 = 3'b111
  } hdps_parse_type;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_PRE = 3'b001, T_SDLY = 3'b010, T_CTS = 3'b011,
    T_SEND = 3'b100, T_OFF = 3'b101, T_WACK = 3'b110
  } hdps_tx_type;

  typedef enum logic [1:0] {
    K_ACK = 2'b00, K_EOT = 2'b01, K_MSG = 2'b10
  } hdps_kind_type;
endpackage

// *** logic/hdps_tick.sv ***
// time base: 1 ms and 20 ms one-cycle enable pulses
// assumes MS_CYC clock cycles make one millisecond
`timescale 1ns/1ps
module hdps_tick #(
  parameter int MS_CYC = hdps_pkg::MS_TICK_CYC
) (
  input  wire logic core_clk,
  input  wire logic reset,
  output logic      ms_tick,
  output logic      slow_tick
);
  import hdps_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [4:0]       ms_cnt;
    logic             ms;
    logic             slow;
  } hdps_tick_st_type;

  hdps_tick_st_type s_q, s_d;

  // divide the clock, then divide milliseconds by twenty
  always_comb begin
    s_d      = s_q;
    s_d.ms   = 1'b0;
    s_d.slow = 1'b0;
    if (s_q.cnt == DIV_W'(MS_CYC - 1)) begin
      s_d.cnt = '0;
      s_d.ms  = 1'b1;
      if (s_q.ms_cnt == 5'(SLOW_TICK_MS - 1)) begin
        s_d.ms_cnt = '0;
        s_d.slow   = 1'b1;
      end else begin
        s_d.ms_cnt = s_q.ms_cnt + 5'h01;
      end
    end else begin
      s_d.cnt = s_q.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ms_tick   = s_q.ms;
  assign slow_tick = s_q.slow;
endmodule

// *** logic/hdps_uart.sv ***
// byte serialiser and deserialiser: start, 8 data lsb first, optional even parity, 1 stop
// assumes rxd is synchronous to core_clk and bit_div stays still while the line is busy
`timescale 1ns/1ps
module hdps_uart (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic [hdps_pkg::DIV_W-1:0] bit_div,
  input  wire logic                      parity_even,
  input  wire logic                      rxd,
  input  wire logic                      tx_start,
  input  wire logic [7:0]                tx_byte,
  output logic                           tx_busy,
  output logic                           txd,
  output logic                           rx_valid,
  output logic [7:0]                     rx_byte,
  output logic                           rx_err
);
  import hdps_pkg::*;

  typedef struct packed {
    logic [10:0]      tx_sh;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0]       tx_bits;
    logic             txd;
    logic             rx_on;
    logic [9:0]       rx_sh;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0]       rx_bits;
    logic             rx_valid;
    logic [7:0]       rx_byte;
    logic             rx_err;
  } hdps_uart_st_type;

  hdps_uart_st_type s_q, s_d;
  logic [3:0] frame_len;

  assign frame_len = parity_even ? 4'hb : 4'ha;

  always_comb begin
    s_d          = s_q;
    s_d.rx_valid = 1'b0;
    s_d.rx_err   = 1'b0;
    // transmitter: a start request while busy is dropped
    if (s_q.tx_bits == 4'h0) begin
      s_d.txd = 1'b1;
      if (tx_start) begin
        s_d.tx_sh   = {1'b1, (parity_even ? ^tx_byte : 1'b1), tx_byte, 1'b0};
        s_d.tx_bits = frame_len;
        s_d.tx_cnt  = '0;
        s_d.txd     = 1'b0;
      end
    end else if (s_q.tx_cnt == bit_div - 1'b1) begin
      s_d.tx_cnt  = '0;
      s_d.tx_sh   = {1'b1, s_q.tx_sh[10:1]};
      s_d.tx_bits = s_q.tx_bits - 4'h1;
      s_d.txd     = (s_q.tx_bits == 4'h1) ? 1'b1 : s_q.tx_sh[1];
    end else begin
      s_d.tx_cnt = s_q.tx_cnt + 1'b1;
    end
    // receiver: half a bit to the start centre, then whole bits
    if (!s_q.rx_on) begin
      if (!rxd) begin
        s_d.rx_on   = 1'b1;
        s_d.rx_cnt  = bit_div >> 1;
        s_d.rx_bits = frame_len;
      end
    end else if (s_q.rx_cnt == bit_div - 1'b1) begin
      s_d.rx_cnt  = '0;
      s_d.rx_bits = s_q.rx_bits - 4'h1;
      if (s_q.rx_bits == frame_len && rxd) begin
        s_d.rx_on = 1'b0;               // glitch, not a start bit
      end else if (s_q.rx_bits != frame_len) begin
        s_d.rx_sh = {rxd, s_q.rx_sh[9:1]};
      end
      if (s_q.rx_bits == 4'h1) begin
        s_d.rx_on    = 1'b0;
        s_d.rx_valid = 1'b1;
        s_d.rx_byte  = parity_even ? s_d.rx_sh[7:0] : s_d.rx_sh[8:1];
        s_d.rx_err   = !rxd || (parity_even && (^s_d.rx_sh[8:0]));
      end
    end else begin
      s_d.rx_cnt = s_q.rx_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q       <= '0;
      s_q.txd   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_busy  = (s_q.tx_bits != 4'h0);
  assign txd      = s_q.txd;
  assign rx_valid = s_q.rx_valid;
  assign rx_byte  = s_q.rx_byte;
  assign rx_err   = s_q.rx_err;
endmodule

// *** verif/hdps_master.sv ***
// polling master model: drives the slave's receive line and collects its replies
// assumes BIT_CYC cycles per bit in both directions; stop bits are not judged
`timescale 1ns/1ps
module hdps_master #(
  parameter int BIT_CYC = 64
) (
  input  wire logic core_clk,
  input  wire logic par_even,
  input  wire logic slave_txd,
  output logic      mst_txd
);
  logic [7:0] q[$];
  logic [7:0] rb;
  initial mst_txd = 1'b1;
  // start, 8 data lsb first, even parity when on, stop; line idles high afterwards
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, par_even ? ^b : 1'b1, b, 1'b0};
    for (int i = 0; i < (par_even ? 11 : 10); i++) begin
      @(negedge core_clk);
      mst_txd = f[i];
      repeat (BIT_CYC - 1) @(negedge core_clk);
    end
  endtask
  task automatic send(input logic [7:0] s[$]);
    foreach (s[i]) send_byte(s[i]);
  endtask
  // sample mid-bit; parity and stop are skipped so a slow slave still decodes
  always begin
    @(negedge slave_txd);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      rb[i] = slave_txd;
    end
    repeat (par_even ? 2 * BIT_CYC : BIT_CYC) @(posedge core_clk);
    q.push_back(rb);
  end
endmodule

// *** verif/hdps_link_properties.sv ***
// timing relations on the polled slave link controller ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
module hdps_link_properties
  import hdps_pkg::*;
#(
  parameter int MS_CYC = 50
) (
  input wire logic         core_clk,
  input wire logic         reset,
  input wire hdps_cfg_type cfg,
  input wire logic         rxd,
  input wire logic         cts,
  input wire logic         txd,
  input wire logic         rts,
  input wire logic         out_ready,
  input wire logic         msg_done,
  input wire logic         msg_error,
  input wire logic         rx_msg_valid,
  input wire logic [7:0]   rx_msg_data,
  input wire logic [7:0]   rx_msg_tag
);
  int   quiet_q;
  int   hi_q;
  int   pend_q;
  logic seen_q;
  logic sent_q;
  // saturating idle counts; pend restarts on any master traffic, so it never overstates
  always_ff @(posedge core_clk) begin
    quiet_q <= (reset || !rxd) ? 0 : quiet_q + int'(quiet_q < 32'h3fffffff);
    hi_q    <= (reset || !txd) ? 0 : hi_q + int'(hi_q < 32'h3fffffff);
    pend_q  <= (reset || out_ready || !rxd) ? 0 : pend_q + int'(pend_q < 32'h3fffffff);
    seen_q  <= !reset && (seen_q || !rxd);
    sent_q  <= !reset && !out_ready && (sent_q || !txd);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rts_idle;
    !cfg.modem_hs |-> !rts;
  endproperty
  a_rts_idle: assert property (p_rts_idle) else $error("rts without handshaking");
  property p_cts_gate;
    cfg.modem_hs && rts && !cts && txd |=> txd;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("sent while cts low");
  property p_rts_hold;
    !$past(reset) && $fell(rts) |-> hi_q >= (int'(cfg.rts_off_delay) - 1) * 20 * MS_CYC;
  endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("rts dropped early");
  property p_pre_tx;
    !cfg.modem_hs && $fell(txd) |-> quiet_q >= (int'(cfg.pre_tx_delay) - 1) * MS_CYC;
  endproperty
  a_pre_tx: assert property (p_pre_tx) else $error("reply too soon");
  property p_rts_rise;
    $rose(rts) |-> quiet_q >= (int'(cfg.pre_tx_delay) - 1) * MS_CYC;
  endproperty
  a_rts_rise: assert property (p_rts_rise) else $error("rts raised too soon");
  property p_prompted;
    $fell(txd) |-> seen_q;
  endproperty
  a_prompted: assert property (p_prompted) else $error("unprompted send");
  property p_no_timeout;
    cfg.poll_timeout == 16'h0000 && !sent_q |-> !msg_error;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("timeout while off");
  property p_timeout_min;
    msg_error && !sent_q |-> pend_q >= (int'(cfg.poll_timeout) - 1) * 20 * MS_CYC;
  endproperty
  a_timeout_min: assert property (p_timeout_min) else $error("timeout early");
  property p_slot_free;
    msg_done || msg_error |=> out_ready;
  endproperty
  a_slot_free: assert property (p_slot_free) else $error("slot not freed");
  property p_rx_hold;
    !$past(reset) && !rx_msg_valid |-> $stable(rx_msg_data) && $stable(rx_msg_tag);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx data moved");
endmodule
bind hdps_link hdps_link_properties #(.MS_CYC(MS_CYC)) chk_u (
  .core_clk, .reset, .cfg, .rxd, .cts, .txd, .rts, .out_ready, .msg_done, .msg_error,
  .rx_msg_valid, .rx_msg_data, .rx_msg_tag
);

// *** verif/hdps_link_tb.sv ***
// self-checking bench for the polled slave link controller
// assumes 50 cycles per ms and 64 cycles per bit via shortened parameters
`timescale 1ns/1ps
module hdps_link_tb;
  import hdps_pkg::*;
  logic         core_clk = 1'b0;
  logic         reset    = 1'b1;
  logic         cts      = 1'b0;
  logic         req      = 1'b0;
  logic [7:0]   od       = 8'h00;
  hdps_cfg_type cfg      = '0;
  logic         rxd, txd, rts, out_ready, msg_done, msg_error, rx_msg_valid;
  logic [7:0]   rx_msg_data, rx_msg_tag, stn, t, d;
  int           num_errors = 0;
  int           checks     = 0;
  int           seed       = 42;
  int           n_done, n_err, n_rx, k, mt;
  // 50 MHz
  always #10 core_clk = ~core_clk;
  hdps_link #(.MS_CYC(50), .BIT_DIV_BASE(64)) dut_u (.core_clk, .reset, .cfg, .rxd, .cts, .txd, .rts,
    .outgoing_message_request(req), .outgoing_data(od), .out_ready, .msg_done, .msg_error,
    .rx_msg_valid, .rx_msg_data, .rx_msg_tag);
  hdps_master #(.BIT_CYC(64)) m_u (.core_clk, .par_even(cfg.parity_even), .slave_txd(txd), .mst_txd(rxd));
  // pulses are one cycle wide, so tally them for later count checks
  initial {n_done, n_err, n_rx, mt} = '0;
  always @(posedge core_clk) begin
    n_done += int'(msg_done === 1'b1);
    n_err  += int'(msg_error === 1'b1);
    n_rx   += int'(rx_msg_valid === 1'b1);
  end
  task automatic check(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // an exhausted wait is a mismatch and ends the run
  task automatic hang_if(input logic stuck);
    if (stuck) begin
      check(1'b0, "wait limit");
      finish_test();
    end
  endtask
  task automatic wait_bytes(input int n);
    for (k = 0; k < 20000 && m_u.q.size() < n; k++) @(posedge core_clk);
    hang_if(m_u.q.size() < n);
  endtask
  task automatic expect_q(input logic [7:0] e[$]);
    wait_bytes(e.size());
    foreach (e[i]) check(m_u.q[i] === e[i], "reply byte");
    m_u.q.delete();
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge core_clk);
    check(m_u.q.size() == 0, "unexpected reply");
  endtask
  task automatic wait_cnt(ref int c, input int v);
    for (k = 0; k < 4000 && c < v; k++) @(posedge core_clk);
    hang_if(c < v);
  endtask
  function automatic logic [7:0] bcc(input logic [7:0] a, b, c);
    return 8'h00 - a - b - c;
  endfunction
  function automatic logic [15:0] crc16(input logic [23:0] v);
    crc16 = 16'h0000;
    for (int i = 0; i < 24; i++) crc16 = (crc16[0] ^ v[i]) ? (crc16 >> 1) ^ CRC_POLY : crc16 >> 1;
  endfunction
  task automatic pkt(input logic [7:0] s, input logic bad);
    m_u.send({CH_STX, s, t, d, CH_ETX, bcc(s, t, d) ^ {7'h00, bad}});
  endtask
  task automatic queue_msg();
    @(negedge core_clk);
    req = 1'b1;
    mt++;
    od = 8'($random(seed));
    @(negedge core_clk);
    req = 1'b0;
    check(out_ready === 1'b0, "request not taken");
  endtask
  task automatic poll_msg();
    logic [15:0] c;
    m_u.send({CH_ENQ, stn});
    t = 8'(mt);
    c = crc16({od, t, stn});
    if (cfg.use_crc) expect_q({CH_STX, stn, t, od, CH_ETX, c[7:0], c[15:8]});
    else expect_q({CH_STX, stn, t, od, CH_ETX, bcc(stn, t, od)});
  endtask
  initial begin
    stn = 8'(($random(seed) & 32'hff) % 255);
    cfg.station_number = stn;
    cfg.dup_detect = 1'b1;
    cfg.pre_tx_delay = 16'h0002;
    cfg.msg_retries = 8'h01;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    check(txd === 1'b1 && rts === 1'b0 && out_ready === 1'b1, "reset state");
    // addressed packet, its repeat, a stranger's packet, a corrupted one
    t = 8'($random(seed));
    d = 8'($random(seed));
    pkt(stn, 1'b0);
    expect_q({CH_ACK});
    check(n_rx == 1 && rx_msg_data === d && rx_msg_tag === t, "delivery");
    pkt(stn, 1'b0);
    expect_q({CH_ACK});
    check(n_rx == 1, "repeat delivered");
    d = ~d;
    pkt(stn + 8'h01, 1'b0);
    quiet(2000);
    pkt(stn, 1'b1);
    quiet(2000);
    check(n_rx == 1, "bad packet delivered");
    $display("packet test done");
    // idle polls: foreign station, plain reply, suppressed reply
    m_u.send({CH_ENQ, stn ^ 8'h80});
    quiet(2000);
    for (int s = 0; s < 2; s++) begin
      @(negedge core_clk);
      cfg.idle_reply_suppress = s[0];
      m_u.send({CH_ENQ, stn});
      if (s == 0) expect_q({CH_EOT, stn});
      else quiet(2000);
    end
    $display("poll test done");
    // queued message leaves only on a poll; nak retried once, then dropped
    queue_msg();
    quiet(3000);
    poll_msg();
    m_u.send({CH_ACK});
    wait_cnt(n_done, 1);
    queue_msg();
    poll_msg();
    m_u.send({CH_NAK});
    poll_msg();
    m_u.send({CH_NAK});
    wait_cnt(n_err, 1);
    check(n_done == 1, "done count");
    $display("message test done");
    // a short poll timeout drops a waiting message, zero lets it wait
    @(negedge core_clk);
    cfg.poll_timeout = 16'h0002;
    queue_msg();
    wait_cnt(n_err, 2);
    @(negedge core_clk);
    cfg.poll_timeout = 16'h0000;
    queue_msg();
    repeat (4000) @(posedge core_clk);
    check(n_err == 2 && out_ready === 1'b0, "message dropped");
    poll_msg();
    m_u.send({CH_ACK});
    wait_cnt(n_done, 2);
    $display("timeout test done");
    // modem: rts, send delay, cts hold-off, off delay
    @(negedge core_clk);
    cfg.modem_hs = 1'b1;
    cfg.idle_reply_suppress = 1'b0;
    cfg.rts_send_delay = 16'h0001;
    cfg.rts_off_delay = 16'h0002;
    m_u.send({CH_ENQ, stn});
    for (k = 0; k < 4000 && rts !== 1'b1; k++) @(posedge core_clk);
    hang_if(rts !== 1'b1);
    quiet(1500);
    @(negedge core_clk);
    cts = 1'b1;
    expect_q({CH_EOT, stn});
    for (k = 0; k < 4000 && rts !== 1'b0; k++) @(posedge core_clk);
    hang_if(rts !== 1'b0);
    @(negedge core_clk);
    cts = 1'b0;
    cfg.modem_hs = 1'b0;
    cfg.parity_even = 1'b1;
    cfg.use_crc = 1'b1;
    m_u.send({CH_ENQ, stn});
    expect_q({CH_EOT, stn});
    queue_msg();
    poll_msg();
    m_u.send({CH_ACK});
    wait_cnt(n_done, 3);
    $display("modem and parity test done");
    finish_test();
  end
endmodule
